// ==== common/psf_pkg.sv ====
// shared constants for the serial potentiometer front end and its bus master
// assumes a single 200 MHz clock on both ends and software behind apb on the master
package psf_pkg;
  // slave address fields
  localparam logic [3:0] DEV_TYPE = 4'ha;  // device_type_field value that selects us
  localparam logic [2:0] SEL_POT = 3'h7;   // internal_select_field: potentiometer group
  localparam logic [2:0] SEL_CSR = 3'h2;   // internal_select_field: control_status_register
  // instruction byte of a potentiometer write
  localparam int INSTR_NV_BIT = 7;         // set: also program the persistent store
  localparam logic [1:0] PTR_RESERVED = 2'h3;
  // control_status_register layout and reset
  localparam int LATCH_BIT = 1;            // write_enable_latch position
  localparam logic [7:0] CSR_RESET = 8'h00;
  // potentiometer sizes, limits and initial wiper values
  localparam int TAPS0 = 64;
  localparam int TAPS1 = 100;
  localparam int TAPS2 = 256;
  localparam logic [7:0] WIPER_MAX0 = 8'h3f;
  localparam logic [7:0] WIPER_MAX1 = 8'h63;
  localparam logic [7:0] WIPER_MAX2 = 8'hff;
  localparam logic [7:0] WIPER0_INIT = 8'h3f;
  localparam logic [7:0] WIPER1_INIT = 8'h00;
  localparam logic [7:0] WIPER2_INIT = 8'hff;
  localparam logic [7:0] STORE_RESET = 8'h00;  // factory content of the persistent store
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // master register map and fields
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_ACKN_BIT = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACKN_BIT = 1;
  localparam int STAT_RX_LSB = 8;
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } psf_op_t;
endpackage

// ==== common/psf_if.sv ====
// two-wire link between the bus master and the potentiometer front end
// both wires are open drain with pull-ups; an enable pulls the wire low
`timescale 1ns/1ps
interface psf_if;
  logic scl_oe;   // master pulls scl low
  logic hsda_oe;  // master pulls sda low
  logic dsda_oe;  // device pulls sda low
  logic scl_line; // resolved scl level
  logic sda_line; // resolved sda level
  // wired-and of the open-drain drivers
  assign scl_line = ~scl_oe;
  assign sda_line = ~(hsda_oe | dsda_oe);
  modport host(output scl_oe, output hsda_oe, input sda_line);
  modport dev(output dsda_oe, input scl_line, input sda_line);
endinterface

// ==== src/psf_device.sv ====
// two-wire slave front end of a triple potentiometer with wiper tap decode
// assumes the master drives scl; both wires arrive asynchronously and are synchronised
// Functional notes
// - start is sda falling, scl high
// - stop is sda rising, scl high
// - stop after a read enters standby
// - master stops only with sda released
// - eight bits, then receiver acknowledges low
// - acknowledge address only on identifier match
// - acknowledge every written byte
// - read: send byte, continue on acknowledge
// - no acknowledge ends reading until stop
// - device type field must be 1010
// - selector 111 pots, 010 control register
// - direction bit one reads, zero writes
// - pot writes need write enable latch
// - persistent write starts programming, refuses commands
// - no acknowledge while programming runs
// - master polls address until acknowledged
// - pots have 64, 100, 256 positions
// - exactly one tap switch per array; two stay on for one cycle after a move
// - power-up recalls wipers from store
// - initial wipers 63, 0, 255
// - wiper value decodes to one tap
// - make new tap before breaking old
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module psf_device
  import psf_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF  // programming time in clock cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  psf_if.dev bus,
  output logic [TAPS0-1:0] tap0_on,  // tap switches of the 64 position array
  output logic [TAPS1-1:0] tap1_on,  // tap switches of the 100 position array
  output logic [TAPS2-1:0] tap2_on,  // tap switches of the 256 position array
  output logic standby,              // standby power state after a read
  output logic prog_busy             // persistent store programming in progress
);
  localparam int BW = $clog2(PROG_CYCLES + 1);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_WR_BYTE = 8'h08,
    ST_WR_ACK = 8'h10,
    ST_RD_BYTE = 8'h20,
    ST_RD_ACK = 8'h40,
    ST_IGNORE = 8'h80
  } psf_dstate_t;

  psf_dstate_t state_reg;                // link state
  logic scl_s1, scl_s2, scl_s3;          // scl synchroniser and history
  logic sda_s1, sda_s2, sda_s3;          // sda synchroniser and history
  logic [3:0] cnt_reg;                   // bits of the current byte
  logic [7:0] shift_reg;                 // received byte
  logic dsda_oe_reg;                     // we pull sda low
  logic rd_reg;                          // transaction is a read
  logic pot_reg;                         // potentiometer group addressed
  logic [1:0] byte_idx_reg;              // bytes written after the address
  logic [1:0] ptr_reg;                   // selected potentiometer
  logic nv_reg;                          // current write also programs the store
  logic [7:0] csr_reg;                   // control_status_register
  logic [7:0] wiper_position_register [3];
  logic [7:0] persistent_wiper_store [3];
  logic [7:0] wiper_old_reg [3];         // wiper one cycle ago, for make before break
  logic recall_done_reg;                 // power-up recall finished
  logic pend_reg;                        // persistent write waits for its stop
  logic busy_reg;                        // programming cycle running
  logic [BW-1:0] prog_cnt_reg;           // programming cycles left
  logic standby_reg;
  logic [TAPS0-1:0] tap0_reg;
  logic [TAPS1-1:0] tap1_reg;
  logic [TAPS2-1:0] tap2_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic addr_ok, wr_strobe, pot_wr, nv_wr;
  logic [7:0] tx_byte;
  logic [255:0] dec_new [3];
  logic [255:0] dec_old [3];

  // limit a data byte to the highest tap; values never roll over
  function automatic logic [7:0] wiper_clamp(input logic [1:0] k, input logic [7:0] d);
    logic [7:0] m;
    m = (k == 2'h0) ? WIPER_MAX0 : ((k == 2'h1) ? WIPER_MAX1 : WIPER_MAX2);
    return (d > m) ? m : d;
  endfunction

  // one-hot position of a wiper value
  function automatic logic [255:0] tap_decode(input logic [7:0] p);
    return 256'h1 << p;
  endfunction

  // two flops per wire, a third only for edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= bus.scl_line;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda_line;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // bus conditions, seen on the synchronised levels
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // address match: type field, a valid selector, and no programming running
  assign addr_ok = (shift_reg[7:4] == DEV_TYPE)
    && ((shift_reg[3:1] == SEL_POT) || (shift_reg[3:1] == SEL_CSR))
    && !busy_reg;

  // a written byte is complete at the fall that ends its eighth clock
  assign wr_strobe = (state_reg == ST_WR_BYTE) && scl_fall && (cnt_reg == 4'h8)
    && !start_det && !stop_det;
  assign pot_wr = wr_strobe && pot_reg && (byte_idx_reg == 2'h1) && (ptr_reg != PTR_RESERVED)
    && csr_reg[LATCH_BIT];
  assign nv_wr = (pot_wr && nv_reg) || (wr_strobe && !pot_reg && (byte_idx_reg == 2'h0));

  // read data: selected wiper or the control register
  assign tx_byte = pot_reg ? wiper_position_register[ptr_reg] : csr_reg;

  // byte engine; sda only changes after a falling scl edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      dsda_oe_reg <= 1'b0;
      rd_reg <= 1'b0;
      pot_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
    end else if (start_det) begin
      // a start restarts address reception from any state
      state_reg <= ST_ADDR;
      cnt_reg <= 4'h0;
      dsda_oe_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      dsda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_IGNORE: begin
          // nothing but a start or a stop leaves these states
        end
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && (cnt_reg == 4'h8)) begin
            if (state_reg == ST_WR_BYTE) begin
              dsda_oe_reg <= 1'b1;
              state_reg <= ST_WR_ACK;
              if (byte_idx_reg != 2'h3) begin
                byte_idx_reg <= byte_idx_reg + 2'h1;
              end
            end else if (addr_ok) begin
              dsda_oe_reg <= 1'b1;
              rd_reg <= shift_reg[0];
              pot_reg <= (shift_reg[3:1] == SEL_POT);
              state_reg <= ST_ADDR_ACK;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            if (rd_reg) begin
              dsda_oe_reg <= ~tx_byte[7];
              state_reg <= ST_RD_BYTE;
            end else begin
              dsda_oe_reg <= 1'b0;
              state_reg <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            dsda_oe_reg <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              dsda_oe_reg <= 1'b0;
              state_reg <= ST_RD_ACK;
            end else begin
              dsda_oe_reg <= ~tx_byte[~cnt_reg[2:0]];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_s2) begin
            state_reg <= ST_IGNORE;
          end else if (scl_fall) begin
            cnt_reg <= 4'h0;
            dsda_oe_reg <= ~tx_byte[7];
            state_reg <= ST_RD_BYTE;
          end
        end
      endcase
    end
  end

  // instruction byte: pointer and persistence select; dummy writes set the read pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= 2'h0;
      nv_reg <= 1'b0;
    end else if (wr_strobe && pot_reg && (byte_idx_reg == 2'h0)) begin
      ptr_reg <= shift_reg[1:0];
      nv_reg <= shift_reg[INSTR_NV_BIT];
    end
  end

  // control register write; every such write is a persistent one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_reg <= CSR_RESET;
    end else if (wr_strobe && !pot_reg && (byte_idx_reg == 2'h0)) begin
      csr_reg <= shift_reg;
    end
  end

  // wipers: initial values, then one recall, then link writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_position_register[0] <= WIPER0_INIT;
      wiper_position_register[1] <= WIPER1_INIT;
      wiper_position_register[2] <= WIPER2_INIT;
      recall_done_reg <= 1'b0;
    end else if (!recall_done_reg) begin
      for (int k = 0; k < 3; k++) begin
        wiper_position_register[k] <= persistent_wiper_store[k];
      end
      recall_done_reg <= 1'b1;
    end else if (pot_wr) begin
      wiper_position_register[ptr_reg] <= wiper_clamp(ptr_reg, shift_reg);
    end
  end

  // persistent store; its content survives only as long as the reset stays released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 3; k++) begin
        persistent_wiper_store[k] <= STORE_RESET;
      end
    end else if (pot_wr && nv_reg) begin
      persistent_wiper_store[ptr_reg] <= wiper_clamp(ptr_reg, shift_reg);
    end
  end

  // programming starts only at the stop that closes a persistent write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else if (nv_wr) begin
      pend_reg <= 1'b1;
    end else if (stop_det && pend_reg) begin
      pend_reg <= 1'b0;
      busy_reg <= 1'b1;
      prog_cnt_reg <= BW'(PROG_CYCLES - 1);
    end else if (start_det) begin
      pend_reg <= 1'b0;  // a restart before the stop abandons the programming cycle
    end else if (busy_reg) begin
      if (prog_cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        prog_cnt_reg <= prog_cnt_reg - BW'(1);
      end
    end
  end

  // standby after a read is closed; any start wakes the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_reg <= 1'b0;
    end else if (start_det) begin
      standby_reg <= 1'b0;
    end else if (stop_det && rd_reg && (state_reg != ST_IDLE)) begin
      standby_reg <= 1'b1;
    end
  end

  // decode current and previous wiper
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      dec_new[k] = tap_decode(wiper_position_register[k]);
      dec_old[k] = tap_decode(wiper_old_reg[k]);
    end
  end

  // for one cycle after a move both taps are on, never none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_old_reg[0] <= WIPER0_INIT;
      wiper_old_reg[1] <= WIPER1_INIT;
      wiper_old_reg[2] <= WIPER2_INIT;
      tap0_reg <= TAPS0'(1) << WIPER0_INIT;
      tap1_reg <= TAPS1'(1) << WIPER1_INIT;
      tap2_reg <= TAPS2'(1) << WIPER2_INIT;
    end else begin
      for (int k = 0; k < 3; k++) begin
        wiper_old_reg[k] <= wiper_position_register[k];
      end
      tap0_reg <= dec_new[0][TAPS0-1:0] | dec_old[0][TAPS0-1:0];
      tap1_reg <= dec_new[1][TAPS1-1:0] | dec_old[1][TAPS1-1:0];
      tap2_reg <= dec_new[2][TAPS2-1:0] | dec_old[2][TAPS2-1:0];
    end
  end

  assign bus.dsda_oe = dsda_oe_reg;
  assign tap0_on = tap0_reg;
  assign tap1_on = tap1_reg;
  assign tap2_on = tap2_reg;
  assign standby = standby_reg;
  assign prog_busy = busy_reg;
endmodule

// ==== src/psf_host.sv ====
// two-wire bus master driven by software over apb, one bus operation per command
// assumes the slave never stretches scl; sda is synchronised before it is sampled
`timescale 1ns/1ps
module psf_host
  import psf_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYCLES  // clock cycles per quarter of an scl period
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  psf_if.host bus
);
  localparam int QW = $clog2(QTR + 1);

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
  } psf_hstate_t;

  psf_hstate_t state_reg;
  logic [QW-1:0] qcnt_reg;    // quarter period divider
  logic [1:0] phase_reg;      // quarter within the current bit
  logic [3:0] bitn_reg;       // bit of the nine-bit frame
  logic [8:0] out_reg;        // bits to send, msb first; ones release sda
  logic [8:0] in_reg;         // sampled sda bits
  logic [7:0] rx_reg;         // last byte received
  logic ackn_reg;             // last acknowledge bit, 1 = not acknowledged
  logic scl_oe_reg, sda_oe_reg;
  logic sda_s1, sda_s2;       // sda synchroniser
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic tick, cmd_wr;
  psf_op_t op;

  assign tick = (state_reg != H_IDLE) && (qcnt_reg == QW'(QTR - 1));
  assign cmd_wr = psel && penable && pwrite && (paddr == CMD_OFS) && (state_reg == H_IDLE);
  assign op = psf_op_t'(pwdata[CMD_OP_LSB+1:CMD_OP_LSB]);

  // sda comes from the wire, so two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda_line;
      sda_s2 <= sda_s1;
    end
  end

  // quarter period enable, only while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_reg <= '0;
    end else if (state_reg == H_IDLE || tick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + QW'(1);
    end
  end

  // operation sequencer; commands while busy are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= H_IDLE;
      phase_reg <= 2'h0;
      bitn_reg <= 4'h0;
      out_reg <= 9'h1ff;
      in_reg <= 9'h000;
      rx_reg <= 8'h00;
      ackn_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (cmd_wr) begin
      phase_reg <= 2'h0;
      bitn_reg <= 4'h0;
      unique case (op)
        OP_START: state_reg <= H_START;
        OP_STOP: state_reg <= H_STOP;
        OP_WRITE: begin
          out_reg <= {pwdata[7:0], 1'b1};
          state_reg <= H_BIT;
        end
        OP_READ: begin
          out_reg <= {8'hff, pwdata[CMD_ACKN_BIT]};
          state_reg <= H_BIT;
        end
      endcase
    end else if (tick) begin
      phase_reg <= phase_reg + 2'h1;
      unique case (state_reg)
        H_IDLE: begin
          // no ticks while idle
        end
        H_START: begin
          // release sda, raise scl, then sda falls while scl is high
          unique case (phase_reg)
            2'h0: sda_oe_reg <= 1'b0;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b1;
            2'h3: begin
              scl_oe_reg <= 1'b1;
              state_reg <= H_IDLE;
            end
          endcase
        end
        H_BIT: begin
          unique case (phase_reg)
            2'h0: sda_oe_reg <= ~out_reg[8];
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: in_reg <= {in_reg[7:0], sda_s2};
            2'h3: begin
              scl_oe_reg <= 1'b1;
              out_reg <= {out_reg[7:0], 1'b1};
              bitn_reg <= bitn_reg + 4'h1;
              if (bitn_reg == 4'h8) begin
                rx_reg <= in_reg[8:1];
                ackn_reg <= in_reg[0];
                state_reg <= H_IDLE;
              end
            end
          endcase
        end
        H_STOP: begin
          // scl low: pull sda, raise scl, then sda rises while scl is high
          unique case (phase_reg)
            2'h0: sda_oe_reg <= 1'b1;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b0;
            2'h3: state_reg <= H_IDLE;
          endcase
        end
      endcase
    end
  end

  // apb slave without wait states; read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata_reg <= 32'h0;
        if (paddr == STAT_OFS) begin
          prdata_reg[STAT_BUSY_BIT] <= (state_reg != H_IDLE) || cmd_wr;
          prdata_reg[STAT_ACKN_BIT] <= ackn_reg;
          prdata_reg[STAT_RX_LSB+7:STAT_RX_LSB] <= rx_reg;
        end
      end
    end
  end

  assign bus.scl_oe = scl_oe_reg;
  assign bus.hsda_oe = sda_oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

// ==== sim/psf_checker.sv ====
// link checker: scl and sda timing seen on the wires
// assumes one pclk for both ends, placed beside the interface
`timescale 1ns/1ps
module psf_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_oe,
  input wire logic hsda_oe,
  input wire logic dsda_oe,
  input wire logic scl_line,
  input wire logic sda_line
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic scl_d; // last scl level
  logic sda_d; // last sda level
  logic [7:0] rises; // scl rises since start, saturates so long reads cannot wrap
  // a start clears the count of scl rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rises <= 8'h00;
    end else begin
      scl_d <= scl_line;
      sda_d <= sda_line;
      if (scl_d && scl_line && sda_d && !sda_line) begin
        rises <= 8'h00;
      end else if (!scl_d && scl_line && rises != 8'hff) begin
        rises <= rises + 8'h01;
      end
    end
  end
  a_dev_pull_low: assert property ($rose(dsda_oe) |-> !scl_line)
    else $error("device pulled sda with scl high");
  a_dev_free_low: assert property ($fell(dsda_oe) |-> !scl_line)
    else $error("device freed sda with scl high");
  a_ack_hold: assert property ($rose(scl_line) && dsda_oe |-> dsda_oe [*8])
    else $error("device sda not held over scl high");
  a_ack_after_eight: assert property ($rose(dsda_oe) |-> rises >= 8'h08)
    else $error("device drove sda before eight bits");
  a_scl_high_len: assert property ($rose(scl_line) |-> scl_line [*8])
    else $error("scl high too short");
  a_scl_low_len: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("scl low too short");
  a_start_shape: assert property ($rose(hsda_oe) && scl_line |-> scl_line [*5])
    else $error("start without scl held high");
  a_stop_quiet: assert property ($rose(sda_line) && scl_d |-> !dsda_oe [*8])
    else $error("device drove sda after stop");
endmodule

// ==== sim/pot_serial_slave_front_end_tb.sv ====
// bench: apb driven master and potentiometer front end joined by the link
// assumes short programming time and quarter period set at the instances
`timescale 1ns/1ps
module pot_serial_slave_front_end_tb
  import psf_pkg::*;
;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h want %0h", $time, (a), (b)); end end
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby, prog_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st; // st: last status word read
  logic [TAPS0-1:0] tap0_on;
  logic [TAPS1-1:0] tap1_on;
  logic [TAPS2-1:0] tap2_on;
  int n_mismatch = 0, cmp_count = 0, mbb = 0; // mbb: cycles with two taps on
  int wiper[3]; // model wiper positions
  int wmax[3] = '{63, 99, 255};
  bit latch; // model write enable latch
  psf_if bus();
  // programming must outlast the first poll, which lands about 260 cycles after the stop
  psf_device #(.PROG_CYCLES(1000)) psf_device_inst(.pclk(pclk), .presetn(presetn),
    .bus(bus), .tap0_on(tap0_on), .tap1_on(tap1_on), .tap2_on(tap2_on),
    .standby(standby), .prog_busy(prog_busy));
  psf_host #(.QTR(6)) psf_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus));
  psf_checker psf_checker_inst(.pclk(pclk), .presetn(presetn), .scl_oe(bus.scl_oe),
    .hsda_oe(bus.hsda_oe), .dsda_oe(bus.dsda_oe), .scl_line(bus.scl_line),
    .sda_line(bus.sda_line));
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // one link operation, then status polled until idle
  task automatic op(input psf_op_t o, input logic [7:0] b, input logic nk);
    apb(1'b1, CMD_OFS, {21'h0, nk, o, b});
    do apb(1'b0, STAT_OFS, 32'h0); while (st[STAT_BUSY_BIT] !== 1'b0);
  endtask
  // taps against the model positions
  task automatic chk_taps();
    `CHK(tap0_on, 64'h1 << wiper[0])
    `CHK(tap1_on, 100'h1 << wiper[1])
    `CHK(tap2_on, 256'h1 << wiper[2])
  endtask
  // address polling; first try must fall while programming runs
  task automatic poll();
    logic ak;
    for (int k = 0; k < 8; k++) begin
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, {DEV_TYPE, SEL_POT, 1'b0}, 1'b0);
      ak = st[STAT_ACKN_BIT];
      op(OP_STOP, 8'h00, 1'b0);
      if (k == 0) `CHK(ak, 1'b1)
      else if (ak === 1'b0) break;
    end
    `CHK(ak, 1'b0)
  endtask
  // pot write: address, instruction, data, stop
  task automatic pwr(input logic [7:0] ins, input logic [7:0] d);
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {DEV_TYPE, SEL_POT, 1'b0}, 1'b0);
    op(OP_WRITE, ins, 1'b0);
    op(OP_WRITE, d, 1'b0);
    `CHK(st[STAT_ACKN_BIT], 1'b0)
    op(OP_STOP, 8'h00, 1'b0);
    if (latch) wiper[ins[1:0]] = (d > wmax[ins[1:0]]) ? wmax[ins[1:0]] : d;
    `CHK(prog_busy, latch & ins[INSTR_NV_BIT])
    if (prog_busy === 1'b1) poll();
  endtask
  // read two bytes, acked then refused, then stop
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, a, 1'b0);
    op(OP_READ, 8'h00, 1'b0);
    `CHK(st[STAT_RX_LSB +: 8], e)
    op(OP_READ, 8'h00, 1'b1);
    `CHK(st[STAT_RX_LSB +: 8], e)
    op(OP_STOP, 8'h00, 1'b0);
    `CHK(standby, 1'b1)
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // taps: one or two on; cycles with two on are counted in mbb
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      `CHK({$countones(tap0_on) inside {[1:2]}, $countones(tap1_on) inside {[1:2]},
        $countones(tap2_on) inside {[1:2]}}, 3'h7)
      if ($countones(tap0_on) == 2 || $countones(tap1_on) == 2
        || $countones(tap2_on) == 2) mbb++;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard, well past the expected run
  initial begin
    #300000;
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [1:0] p;
    logic ex; // expected refusal of an address
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    wiper = '{0, 0, 0};
    st = $urandom(32'h8cd829d6);
    repeat (3) @(posedge pclk);
    `CHK({tap0_on[63], tap1_on[0], tap2_on[255]}, 3'h7)
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk_taps();
    mbb = 0; // the recall move after reset must not stand in for a link write
    // every selector, plus a wrong device type; refused bytes stay refused
    for (int i = 0; i < 9; i++) begin
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, (i == 8) ? 8'h5e : {DEV_TYPE, 3'(i), 1'b0}, 1'b0);
      ex = !(i < 8 && (3'(i) == SEL_POT || 3'(i) == SEL_CSR));
      `CHK(st[STAT_ACKN_BIT], ex)
      if (st[STAT_ACKN_BIT]) op(OP_WRITE, 8'($urandom), 1'b0);
      `CHK(st[STAT_ACKN_BIT], ex)
      op(OP_STOP, 8'h00, 1'b0);
    end
    if (prog_busy === 1'b1) poll();
    pwr(8'h80, 8'h15);
    chk_taps();
    op(OP_START, 8'h00, 1'b0);
    op(OP_WRITE, {DEV_TYPE, SEL_CSR, 1'b0}, 1'b0);
    op(OP_WRITE, 8'(1 << LATCH_BIT), 1'b0);
    op(OP_STOP, 8'h00, 1'b0);
    latch = 1'b1;
    `CHK(prog_busy, 1'b1)
    poll();
    for (int i = 0; i < 6; i++) begin
      p = 2'($urandom % 3);
      pwr({1'($urandom), 5'h00, p}, 8'($urandom));
      chk_taps();
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, {DEV_TYPE, SEL_POT, 1'b0}, 1'b0);
      op(OP_WRITE, {6'h00, p}, 1'b0);
      op(OP_STOP, 8'h00, 1'b0);
      rd({DEV_TYPE, SEL_POT, 1'b1}, 8'(wiper[p]));
    end
    rd({DEV_TYPE, SEL_CSR, 1'b1}, 8'(1 << LATCH_BIT));
    apb(1'b0, 12'h008, 32'h0);
    `CHK({pslverr, st}, 33'h0)
    `CHK(mbb > 0, 1'b1)
    conclude();
  end
endmodule
